/* design/eeprom_pkg.sv */
// Shared constants for the serial EEPROM slave
package eeprom_pkg;
  localparam logic [3:0] TYPE_CODE = 4'hA;
  localparam int ADDR_W = 16;
  localparam int ARRAY_TOP = 16'h07FF;
  localparam int CACHE_BYTES = 64;
  localparam int PAGE_BYTES = 8;
  localparam int PAGES = 8;
  localparam int CLK_MHZ = 100;
  localparam int PAGE_PROG_US = 5000;
  localparam int PAGE_PROG_CYC = PAGE_PROG_US * CLK_MHZ;
  localparam int MEM_DEPTH = 4096;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_CTRL = 4'h1,
    ST_ADDR_HI = 4'h3,
    ST_ADDR_LO = 4'h2,
    ST_WDATA = 4'h6,
    ST_RDATA = 4'h7,
    ST_RACK = 4'h5,
    ST_IGNORE = 4'h4
  } link_state_e;
  typedef enum logic [1:0] {
    PG_IDLE = 2'h0,
    PG_COPY = 2'h1,
    PG_WAIT = 2'h3
  } prog_state_e;
endpackage

/* design/eeprom_array.sv */
// Array memory with registered read data and byte write port
`timescale 1ns/1ns
module eeprom_array #(
  parameter int DEPTH = 4096,
  parameter int AW = 12
) (
  // Clock
  input wire logic clock,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // Read port
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clock) begin
    rd_data <= mem[rd_addr];
  end
endmodule // eeprom_array

/* design/write_cache.sv */
// Sixty-four byte write cache with per-byte valid flags
`timescale 1ns/1ns
module write_cache #(
  parameter int BYTES = 64
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Load side
  input wire logic clear,
  input wire logic ld_en,
  input wire logic [5:0] ld_idx,
  input wire logic [7:0] ld_data,
  // Drain side
  input wire logic [5:0] rd_idx,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic [7:0] page_used
);
  logic [7:0] mem [BYTES];
  logic [BYTES-1:0] valid_q;

  always_ff @(posedge clock) begin
    if (ld_en) begin
      mem[ld_idx] <= ld_data;
    end
    rd_data <= mem[rd_idx];
  end

  always_ff @(posedge clock) begin
    if (reset || clear) begin
      valid_q <= '0;
    end else if (ld_en) begin
      valid_q[ld_idx] <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= valid_q[rd_idx];
    end
  end

  genvar g;
  for (g = 0; g < 8; g++) begin : g_used
    assign page_used[g] = |valid_q[g*8 +: 8];
  end
endmodule // write_cache

/* design/eeprom_slave.sv */
// Two-wire serial EEPROM slave: control byte, pointer, reads, cache writes
//
// Behaviour
// - First byte after start is type code, three select bits, direction bit.
// - Acknowledged read byte makes device send the next sequential byte.
// - Address pointer increments by one after every byte operation.
// - Pointer runs past top array address instead of wrapping to zero.
// - Write cache holds 64 bytes, eight pages of eight bytes.
// - Write data loads cache until stop; stop launches programming.
// - Programming lasts fixed time per used page, partial page counts full.
// - Beyond 64 bytes the cache pointer wraps to page zero, overwriting.
// - During programming every command is ignored and never acknowledged.
// - Page-aligned write programs all cached data at consecutive addresses.
// - Every cache page transferred gets its own programming cycle.
// - First data byte goes into page zero at low three address bits.
// - Mid-page start wraps trailing bytes into empty head of page zero.
// - Cache page zero goes to addressed page, later pages consecutively.
// - Partial page programs only received bytes, others stay unchanged.
// - After stop and finished activity, device enters standby, errors included.
// - Low supply blocks programming; monitor disabled during standby.
// - Respond only when select bits match chip address pins.
// - Data line only pulled low or released, never driven high.
// - Data changes only while clock low; high-time changes are start/stop.
// - Serial clock is input only, never driven.
`timescale 1ns/1ns
module eeprom_slave
  import eeprom_pkg::*;
#(
  parameter int PROG_CYCLES = PAGE_PROG_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Two-wire bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Chip address pins
  input wire logic chip_select_pin_0,
  input wire logic chip_select_pin_1,
  input wire logic chip_select_pin_2,
  // Supply monitor
  input wire logic supply_low,
  // Status
  output logic standby,
  output logic monitor_enable,
  output logic busy
);
  // Pin synchronisers
  logic [1:0] scl_sync_q, sda_sync_q;
  logic scl_q, sda_q;
  logic [2:0] cs_sync1_q, cs_sync2_q;
  always_ff @(posedge clock) begin
    if (reset) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cs_sync1_q <= 3'h0;
      cs_sync2_q <= 3'h0;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      scl_q <= scl_sync_q[1];
      sda_q <= sda_sync_q[1];
      cs_sync1_q <= {chip_select_pin_2, chip_select_pin_1, chip_select_pin_0};
      cs_sync2_q <= cs_sync1_q;
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = scl_sync_q[1] && !scl_q;
  assign scl_fall = !scl_sync_q[1] && scl_q;
  assign start_det = scl_sync_q[1] && scl_q && sda_q && !sda_sync_q[1];
  assign stop_det = scl_sync_q[1] && scl_q && !sda_q && sda_sync_q[1];

  // Byte framing
  link_state_e state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic ack_phase_q, ack_drive_q, tx_drive_q, master_ack_q;
  logic [ADDR_W-1:0] ptr_q;
  logic [12:0] start_pg_q;
  logic [5:0] cache_idx_q;
  logic [7:0] rd_byte;
  logic prog_busy;

  logic byte_done;
  logic [7:0] rx_byte;
  assign byte_done = scl_fall && bit_cnt_q == 4'h8 && !ack_phase_q;
  assign rx_byte = shift_q;

  logic ctrl_match;
  assign ctrl_match = rx_byte[7:4] == TYPE_CODE && rx_byte[3:1] == cs_sync2_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ack_phase_q <= 1'b0;
      master_ack_q <= 1'b0;
    end else if (start_det || stop_det) begin
      bit_cnt_q <= 4'h0;
      ack_phase_q <= 1'b0;
    end else if (scl_rise && !ack_phase_q) begin
      shift_q <= {shift_q[6:0], sda_q};
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end else if (scl_rise && ack_phase_q) begin
      master_ack_q <= !sda_q;
    end else if (byte_done) begin
      ack_phase_q <= 1'b1;
    end else if (scl_fall && ack_phase_q) begin
      ack_phase_q <= 1'b0;
      bit_cnt_q <= 4'h0;
    end
  end

  // Protocol state
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= ST_IDLE;
    end else if (stop_det) begin
      state_q <= ST_IDLE;
    end else if (start_det) begin
      state_q <= prog_busy ? ST_IGNORE : ST_CTRL;
    end else if (byte_done) begin
      case (state_q)
        ST_CTRL: begin
          if (!ctrl_match) begin
            state_q <= ST_IGNORE;
          end else if (rx_byte[0]) begin
            state_q <= ST_RDATA;
          end else begin
            state_q <= ST_ADDR_HI;
          end
        end
        ST_ADDR_HI: state_q <= ST_ADDR_LO;
        ST_ADDR_LO: state_q <= ST_WDATA;
        ST_RDATA: state_q <= ST_RACK;
        default: state_q <= state_q;
      endcase
    end else if (scl_fall && ack_phase_q && state_q == ST_RACK) begin
      state_q <= master_ack_q ? ST_RDATA : ST_IGNORE;
    end
  end

  // Address pointer and cache index
  logic cache_ld;
  assign cache_ld = byte_done && state_q == ST_WDATA;
  always_ff @(posedge clock) begin
    if (reset) begin
      ptr_q <= 16'h0000;
      start_pg_q <= 13'h0000;
      cache_idx_q <= 6'h00;
    end else if (byte_done && state_q == ST_ADDR_HI) begin
      ptr_q[15:8] <= rx_byte;
    end else if (byte_done && state_q == ST_ADDR_LO) begin
      ptr_q[7:0] <= rx_byte;
      start_pg_q <= {ptr_q[15:8], rx_byte[7:3]};
      cache_idx_q <= {3'h0, rx_byte[2:0]};
    end else if (cache_ld) begin
      ptr_q <= ptr_q + 16'h0001;
      cache_idx_q <= cache_idx_q + 6'h01;
    end else if (byte_done && state_q == ST_RDATA) begin
      ptr_q <= ptr_q + 16'h0001;
    end
  end

  // Transmit shifter, loaded on the fall that ends an acknowledge
  logic [7:0] tx_q;
  always_ff @(posedge clock) begin
    if (reset) begin
      tx_q <= 8'hFF;
    end else if (scl_fall && ack_phase_q && (state_q == ST_RDATA || state_q == ST_RACK)) begin
      tx_q <= rd_byte;
    end else if (scl_fall && state_q == ST_RDATA && !ack_phase_q && bit_cnt_q != 4'h0) begin
      tx_q <= {tx_q[6:0], 1'b1};
    end
  end

  // Drive of the data line, only on clock low
  always_ff @(posedge clock) begin
    if (reset || start_det || stop_det) begin
      ack_drive_q <= 1'b0;
      tx_drive_q <= 1'b0;
    end else if (byte_done) begin
      ack_drive_q <= (state_q == ST_CTRL && ctrl_match) || state_q == ST_ADDR_HI
        || state_q == ST_ADDR_LO || state_q == ST_WDATA;
      tx_drive_q <= 1'b0;
    end else if (scl_fall && ack_phase_q) begin
      ack_drive_q <= 1'b0;
      tx_drive_q <= (state_q == ST_RDATA || (state_q == ST_RACK && master_ack_q)) && !rd_byte[7];
    end else if (scl_fall && state_q == ST_RDATA && !ack_phase_q && bit_cnt_q != 4'h0) begin
      tx_drive_q <= !tx_q[6];
    end
  end
  assign sda_out = 1'b0;
  assign sda_oe = ack_drive_q || tx_drive_q;

  // Cache, array and programmer
  prog_state_e pstate_q;
  logic [2:0] pg_q, byte_q;
  logic [7:0] used_q;
  logic [ADDR_W-1:0] base_q;
  logic [31:0] wait_q;
  logic [7:0] c_data;
  logic c_valid;
  logic [7:0] page_used;
  logic arr_we;
  logic [11:0] arr_waddr;
  logic [15:0] prog_addr;
  logic byte_ready_q;

  write_cache #(.BYTES(CACHE_BYTES)) u_cache (
    .clock(clock),
    .reset(reset),
    .clear(pstate_q == PG_IDLE && state_q == ST_ADDR_LO && byte_done),
    .ld_en(cache_ld),
    .ld_idx(cache_idx_q),
    .ld_data(rx_byte),
    .rd_idx({pg_q, byte_q}),
    .rd_data(c_data),
    .rd_valid(c_valid),
    .page_used(page_used)
  );

  assign prog_addr = base_q + {7'h00, pg_q, 3'h0} + {13'h0000, byte_q};
  assign arr_waddr = prog_addr[11:0];
  assign arr_we = pstate_q == PG_COPY && byte_ready_q && c_valid && !supply_low;

  eeprom_array #(.DEPTH(MEM_DEPTH), .AW(12)) u_array (
    .clock(clock),
    .wr_en(arr_we),
    .wr_addr(arr_waddr),
    .wr_data(c_data),
    .rd_addr(ptr_q[11:0]),
    .rd_data(rd_byte)
  );

  always_ff @(posedge clock) begin
    if (reset) begin
      pstate_q <= PG_IDLE;
      pg_q <= 3'h0;
      byte_q <= 3'h0;
      used_q <= 8'h00;
      base_q <= 16'h0000;
      wait_q <= 32'h0;
      byte_ready_q <= 1'b0;
    end else begin
      case (pstate_q)
        PG_IDLE: begin
          if (stop_det && state_q == ST_WDATA && page_used != 8'h00) begin
            pstate_q <= PG_COPY;
            used_q <= page_used;
            base_q <= {start_pg_q, 3'h0};
            pg_q <= 3'h0;
            byte_q <= 3'h0;
            byte_ready_q <= 1'b0;
          end
        end
        PG_COPY: begin
          if (!used_q[pg_q]) begin
            pstate_q <= PG_IDLE;
          end else if (!byte_ready_q) begin
            byte_ready_q <= 1'b1;
          end else if (byte_q == 3'h7) begin
            pstate_q <= PG_WAIT;
            wait_q <= 32'(PROG_CYCLES);
            byte_ready_q <= 1'b0;
          end else begin
            byte_q <= byte_q + 3'h1;
            byte_ready_q <= 1'b0;
          end
        end
        PG_WAIT: begin
          if (wait_q > 32'h1) begin
            wait_q <= wait_q - 32'h1;
          end else begin
            byte_q <= 3'h0;
            pg_q <= pg_q + 3'h1;
            pstate_q <= (pg_q == 3'h7) ? PG_IDLE : PG_COPY;
          end
        end
        default: pstate_q <= PG_IDLE;
      endcase
    end
  end

  assign prog_busy = pstate_q != PG_IDLE;
  assign busy = prog_busy;
  assign standby = state_q == ST_IDLE && !prog_busy;
  assign monitor_enable = !standby;

  // Checks
  property p_no_ack_busy;
    @(posedge clock) disable iff (reset) prog_busy && $past(prog_busy) |-> !ack_drive_q;
  endproperty
  a_no_ack_busy: assert property (p_no_ack_busy) else $error("ack while programming");
  property p_low_only;
    @(posedge clock) disable iff (reset) sda_oe |-> sda_out == 1'b0;
  endproperty
  a_low_only: assert property (p_low_only) else $error("data line driven high");
  property p_ptr_inc;
    @(posedge clock) disable iff (reset)
      byte_done && (state_q == ST_RDATA || state_q == ST_WDATA) |=> ptr_q == $past(ptr_q) + 16'h0001;
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not advanced");
  property p_no_write_low;
    @(posedge clock) disable iff (reset) supply_low |-> !arr_we;
  endproperty
  a_no_write_low: assert property (p_no_write_low) else $error("write during low supply");
  property p_stop_idle;
    @(posedge clock) disable iff (reset) stop_det |=> state_q == ST_IDLE;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop did not idle");
  property p_prog_launch;
    @(posedge clock) disable iff (reset)
      stop_det && state_q == ST_WDATA && page_used != 8'h00 && !prog_busy |=> prog_busy;
  endproperty
  a_prog_launch: assert property (p_prog_launch) else $error("stop did not launch programming");
  property p_first_idx;
    @(posedge clock) disable iff (reset)
      byte_done && state_q == ST_ADDR_LO |=> cache_idx_q == {3'h0, $past(rx_byte[2:0])};
  endproperty
  a_first_idx: assert property (p_first_idx) else $error("first byte not in page zero");
  property p_sda_on_low;
    @(posedge clock) disable iff (reset) $rose(tx_drive_q) |-> !scl_q;
  endproperty
  a_sda_on_low: assert property (p_sda_on_low) else $error("data changed with clock high");
endmodule // eeprom_slave

/* tb/bus_master.sv */
// Two-wire bus master model: drives the serial clock and an open-drain data line
`timescale 1ns/1ns
module bus_master (
  // Clock
  input wire logic clock,
  // Two-wire bus
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // Clock idles high and data is released between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  // One bit of 8 clocks; data changes only in the low half
  task automatic bit_io(input logic b, output logic r);
    scl <= 1'b0;
    tick(3);
    sda_low <= !b;
    tick(1);
    scl <= 1'b1;
    tick(3);
    r = sda;
    tick(1);
  endtask

  // Start, also usable as repeated start
  task automatic start;
    logic r;
    bit_io(1'b1, r);
    sda_low <= 1'b1;
    tick(4);
  endtask

  task automatic stop;
    logic r;
    bit_io(1'b0, r);
    sda_low <= 1'b0;
    tick(4);
  endtask

  // Byte out, most significant bit first, then sample acknowledge
  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask

  // Byte in; acknowledge to continue, withhold on the last
  task automatic read_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(!more, r);
  endtask
endmodule // bus_master

/* tb/tb_top.sv */
// Self-checking bench for the EEPROM slave
`timescale 1ns/1ns
`define CHECK(what, exp, got) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("mismatch %s expected %0h seen %0h", what, exp, got); \
  end \
end
module tb_top;
  import eeprom_pkg::*;
  localparam int PROG = 200;
  localparam logic [2:0] SEL = 3'h5;
  logic clock = 1'b0;
  logic reset;
  logic supply_low;
  logic [2:0] pins = SEL;
  logic scl, sda_low, sda_out, sda_oe, standby, monitor_enable, busy;
  wire sda = !(sda_oe | sda_low);
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  int busy_cyc = 0;
  logic [7:0] mem [0:4095];

  always #5 clock = ~clock;

  eeprom_slave #(.PROG_CYCLES(PROG)) eeprom_slave_inst (
    .clock(clock), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .chip_select_pin_0(pins[0]), .chip_select_pin_1(pins[1]), .chip_select_pin_2(pins[2]),
    .supply_low(supply_low), .standby(standby), .monitor_enable(monitor_enable), .busy(busy)
  );

  bus_master bus_master_inst (.clock(clock), .scl(scl), .sda_low(sda_low), .sda(sda));

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (busy === 1'b1) busy_cyc++;
    if (cycles == 100000) begin
      miscompares++;
      close_out;
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic ctrl(input logic [3:0] code, input logic [2:0] sel, input logic rd, output logic ack);
    bus_master_inst.start();
    bus_master_inst.write_byte({code, sel, rd}, ack);
  endtask

  task automatic set_addr(input logic [15:0] a);
    logic ack;
    logic [14:0] flat;
    flat = {SEL, a[11:0]};
    ctrl(TYPE_CODE, flat[14:12], 1'b0, ack);
    `CHECK("write ctrl ack", 1'b1, ack)
    bus_master_inst.write_byte({4'h0, flat[11:8]}, ack);
    `CHECK("addr hi ack", 1'b1, ack)
    bus_master_inst.write_byte(a[7:0], ack);
    `CHECK("addr lo ack", 1'b1, ack)
  endtask

  // Write n bytes, poll while busy, then time the programming span
  task automatic write_block(input logic [15:0] a, input int n, input logic [7:0] s, input logic prog);
    logic ack;
    logic [7:0] d;
    logic [11:0] base;
    int pages;
    base = {a[11:3], 3'h0};
    set_addr(a);
    `CHECK("standby active", 1'b0, standby)
    for (int i = 0; i < n; i++) begin
      d = s + 8'(i) * 8'h1D;
      bus_master_inst.write_byte(d, ack);
      `CHECK("data ack", 1'b1, ack)
      if (prog) mem[base + 12'((a[2:0] + i) % 64)] = d;
    end
    pages = (a[2:0] + n - 1) / 8 + 1;
    if (pages > 8) pages = 8;
    busy_cyc = 0;
    bus_master_inst.stop();
    ctrl(TYPE_CODE, SEL, 1'b0, ack);
    `CHECK("poll ack", 1'b0, ack)
    bus_master_inst.stop();
    for (int w = 0; w < 4000 && busy !== 1'b0; w++) tick(1);
    tick(2);
    `CHECK("prog span", 1'b1, busy_cyc >= pages * PROG && busy_cyc <= pages * (PROG + 30))
    `CHECK("standby idle", 1'b1, standby)
    `CHECK("monitor off", 1'b0, monitor_enable)
  endtask

  task automatic read_block(input logic [15:0] a, input int n);
    logic ack;
    logic [7:0] d;
    set_addr(a);
    ctrl(TYPE_CODE, SEL, 1'b1, ack);
    `CHECK("read ctrl ack", 1'b1, ack)
    for (int i = 0; i < n; i++) begin
      bus_master_inst.read_byte(i < n - 1, d);
      `CHECK("read data", mem[12'(a + i)], d)
    end
    bus_master_inst.stop();
  endtask

  task automatic restart_read(input logic [11:0] a);
    logic ack, r;
    logic [7:0] d;
    bus_master_inst.start();
    repeat (3) bus_master_inst.bit_io(1'b0, r);
    ctrl(TYPE_CODE, SEL, 1'b1, ack);
    `CHECK("restart ack", 1'b1, ack)
    bus_master_inst.read_byte(1'b0, d);
    `CHECK("current read", mem[a], d)
    bus_master_inst.stop();
  endtask

  task automatic reject_codes;
    logic ack;
    for (int k = 1; k < 10; k++) begin
      ctrl(k > 7 ? (k == 8 ? 4'hB : 4'h2) : TYPE_CODE, k > 7 ? SEL : SEL ^ k[2:0], k[0], ack);
      `CHECK("foreign ctrl ack", 1'b0, ack)
      bus_master_inst.stop();
    end
  endtask

  task automatic abort_write;
    set_addr(16'h0600);
    bus_master_inst.stop();
    tick(8);
    `CHECK("abort busy", 1'b0, busy)
    `CHECK("abort standby", 1'b1, standby)
  endtask

  initial begin
    reset = 1'b1;
    supply_low = 1'b0;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    tick(6);
    `CHECK("sda_out", 1'b0, sda_out)
    write_block(16'h01E8, 64, 8'h11, 1'b1);
    read_block(16'h01E8, 64);
    write_block(16'h0302, 64, 8'h5A, 1'b1);
    read_block(16'h0300, 64);
    write_block(16'h0400, 66, 8'h33, 1'b1);
    read_block(16'h0400, 64);
    write_block(16'h0500, 8, 8'h21, 1'b1);
    write_block(16'h0503, 3, 8'h90, 1'b1);
    read_block(16'h0500, 8);
    supply_low <= 1'b1;
    write_block(16'h0500, 8, 8'hC3, 1'b0);
    supply_low <= 1'b0;
    read_block(16'h0500, 8);
    write_block(16'h07FC, 8, 8'h44, 1'b1);
    read_block(16'h07FC, 7);
    restart_read(12'h803);
    reject_codes;
    abort_write;
    close_out;
  end
endmodule // tb_top
